//--- mcsp_cfg.svh
`ifndef MCSP_CFG_SVH
`define MCSP_CFG_SVH
`define MCSP_FRAME_BITS 16
`define MCSP_ADDR_MSB 15
`define MCSP_ADDR_LSB 12
`define MCSP_WD_BIT 11
`define MCSP_DATA_MSB 10
`define MCSP_REG_INIT 4'h0
`define MCSP_REG_STAT1 4'h1
`define MCSP_REG_STAT7 4'h7
`define MCSP_REG_OUTCTL 4'h8
`define MCSP_REG_INEN 4'hb
`define MCSP_REG_TEST 4'hf
`define MCSP_SOA_MSB 3
`define MCSP_WDSEL_BIT 10
`define MCSP_DSF_BIT 10
`define MCSP_RCF_BIT 0
`define MCSP_REG_RESET 11'h000
`define MCSP_CLK_MHZ 10
`define MCSP_INIT_US 50
`define MCSP_INIT_CYC (`MCSP_INIT_US * `MCSP_CLK_MHZ)
`endif

//--- mcsp_host_model.sv
`timescale 1ns/1ps
module mcsp_host_model (
  input  wire logic clk_sys,
  input  wire logic sdo,
  input  wire logic sdoOe,
  output logic      sclkIn,
  output logic      chipSelectN,
  output logic      sdi
);
  initial begin
    sclkIn      = 1'b0;
    chipSelectN = 1'b1;
    sdi         = 1'b0;
  end

  // Clock idles low; 4 cycles high, 4 low gives 800 ns
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    logic [15:0] sh;
    sh = tx;
    rx = 16'h0000;
    @(posedge clk_sys);
    chipSelectN <= 1'b0;
    sdi         <= sh[15];
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      sclkIn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      // Released line reads as the inverse of the last bit
      rx = {rx[14:0], sdoOe ? sdo : ~rx[0]};
      @(posedge clk_sys);
      sh = {sh[14:0], ~sh[15]};
      sclkIn <= 1'b0;
      sdi    <= sh[15];
      repeat (4) @(posedge clk_sys);
    end
    chipSelectN <= 1'b1;
    sdi         <= ~sh[15];
    // Frame end reaches the registers after the pin sync
    repeat (12) @(posedge clk_sys);
  endtask
endmodule // mcsp_host_model

//--- mcsp_mode_ctrl.sv
`timescale 1ns/1ps
`include "mcsp_cfg.svh"
module mcsp_mode_ctrl
  import mcsp_pkg::*;
#(
  parameter int WD_SHORT_US = 10000,
  parameter int WD_LONG_US  = 20000,
  parameter int BLANK_US    = 100
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              resetWakeIn,
  input  wire logic [3:0]        wakeIn,
  input  wire logic              limpHomeIn,
  input  wire logic [3:0]        directIn,
  input  wire logic              sclkIn,
  input  wire logic              chipSelectN,
  input  wire logic              sdi,
  input  wire logic [3:0]        overloadIn,
  input  wire logic              underVoltIn,
  input  wire logic [3:0]        overTempIn,
  input  wire logic              ochiCh1In,
  input  wire logic [3:0]        severeShortIn,
  input  wire logic [15:0][10:0] statusWord,
  output logic                   sdo,
  output logic                   sdoOe,
  output logic [5:0]             channelControl,
  output logic [4:0]             ocWindowStart,
  output logic                   lowOcProfile,
  output logic [3:0]             autoRestart,
  output logic [3:0]             latchedOff,
  output logic                   faultReportEn,
  output logic                   pwmEnable,
  output logic                   analogFbEnable,
  output logic                   initDone,
  output logic                   diagAvail,
  output mcsp_mode_t             mode,
  output logic [5:0]             channelOnBit,
  output logic [3:0]             directSel,
  output logic [3:0]             statusOutSelect,
  output logic                   deviceStatusFlag,
  output logic                   registerClearedFlag
);
  localparam int CW = 24;
  localparam logic [CW-1:0] WD_SHORT_CYC =
    CW'(WD_SHORT_US * `MCSP_CLK_MHZ);
  localparam logic [CW-1:0] WD_LONG_CYC =
    CW'(WD_LONG_US * `MCSP_CLK_MHZ);
  localparam logic [CW-1:0] BLANK_CYC = CW'(BLANK_US * `MCSP_CLK_MHZ);
  localparam logic [CW-1:0] INIT_CYC  = CW'(`MCSP_INIT_CYC);

  logic        rstwS;
  logic [3:0]  wakeS;
  logic        limpS;
  logic [3:0]  directS;
  logic        sclkS;
  logic        csS;
  logic        csActS;
  logic        sdiS;

  // Select synced active high so its reset level matches its idle
  mcsp_sync3 #(.W(13)) pinSync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .asyncIn ({resetWakeIn, wakeIn, limpHomeIn, directIn,
               sclkIn, ~chipSelectN, sdi}),
    .level   ({rstwS, wakeS, limpS, directS, sclkS, csActS, sdiS})
  );
  assign csS = !csActS;

  // Mode, timers and fault latches
  logic            spiFail;
  logic            recoverPend;
  logic [CW-1:0]   blankCnt;
  logic [CW-1:0]   initCnt;
  logic [3:0]      wakePrev;
  mcsp_mode_t      next_mode;
  logic [CW-1:0]   next_blankCnt;
  logic [CW-1:0]   next_initCnt;
  logic [3:0]      next_latchedOff;
  logic            wakeCond;
  logic            failCond;
  logic            wakeUp;
  logic            toFail;
  logic            toNormal;
  logic            serialErr;

  assign wakeCond = (|wakeS) | rstwS;
  assign failCond = spiFail | limpS;
  assign wakeUp   = (mode == MCSP_SLEEP) && wakeCond;
  assign toFail   = (mode == MCSP_NORMAL) && wakeCond && failCond;
  assign toNormal = (mode == MCSP_FAIL) && wakeCond && !limpS
                    && recoverPend;

  always_comb begin
    next_mode = mode;
    if (!wakeCond) begin
      next_mode = MCSP_SLEEP;
    end else begin
      case (mode)
        MCSP_SLEEP:  next_mode = limpS ? MCSP_FAIL : MCSP_NORMAL;
        MCSP_NORMAL: next_mode = failCond ? MCSP_FAIL : MCSP_NORMAL;
        MCSP_FAIL:   next_mode = toNormal ? MCSP_NORMAL : MCSP_FAIL;
        default:     next_mode = MCSP_SLEEP;
      endcase
    end
    next_blankCnt = blankCnt;
    next_initCnt  = initCnt;
    if (wakeUp) begin
      next_blankCnt = BLANK_CYC;
      next_initCnt  = INIT_CYC;
    end else begin
      if (blankCnt != '0) next_blankCnt = blankCnt - 1'b1;
      if (initCnt != '0) next_initCnt = initCnt - 1'b1;
    end
    next_latchedOff = latchedOff;
    if (wakeUp || !rstwS) begin
      next_latchedOff = '0;
    end else if (mode == MCSP_FAIL) begin
      next_latchedOff = latchedOff | overTempIn | severeShortIn
                        | {3'b000, ochiCh1In};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode       <= MCSP_SLEEP;
      blankCnt   <= '0;
      initCnt    <= '0;
      latchedOff <= '0;
      wakePrev   <= '0;
    end else begin
      mode       <= next_mode;
      blankCnt   <= next_blankCnt;
      initCnt    <= next_initCnt;
      latchedOff <= next_latchedOff;
      wakePrev   <= wakeS;
    end
  end

  // Serial port, register file and watchdog
  logic [15:0]     rxShift;
  logic [15:0]     txShift;
  logic [7:0]      bitCnt;
  logic            sclkPrev;
  logic            csPrev;
  logic [3:0]      loadedSel;
  logic            lastWd;
  logic            recStage;
  logic [CW-1:0]   wdCnt;
  logic [10:0]     regFile [16];
  logic [15:0]     next_rxShift;
  logic [15:0]     next_txShift;
  logic [7:0]      next_bitCnt;
  logic [3:0]      next_loadedSel;
  logic            next_lastWd;
  logic            next_recStage;
  logic            next_recoverPend;
  logic [CW-1:0]   next_wdCnt;
  logic            next_spiFail;
  logic            next_dsf;
  logic            next_rcf;
  logic [10:0]     next_regFile [16];
  logic            sclkRise;
  logic            csFall;
  logic            frameEnd;
  logic            goodFrame;
  logic            wdTimeout;
  logic [CW-1:0]   wdLimit;
  logic [10:0]     selStatus;
  logic [3:0]      rxAddr;
  logic            rxWd;
  logic            clearAll;

  assign sclkRise  = sclkS && !sclkPrev && !csS;
  assign csFall    = !csS && csPrev;
  assign frameEnd  = csS && !csPrev;
  assign goodFrame = frameEnd && (bitCnt != 8'h00)
                     && (bitCnt[3:0] == 4'h0);
  assign rxAddr    = rxShift[`MCSP_ADDR_MSB:`MCSP_ADDR_LSB];
  assign rxWd      = rxShift[`MCSP_WD_BIT];
  assign wdLimit   = regFile[`MCSP_REG_INIT][`MCSP_WDSEL_BIT] ?
                     WD_LONG_CYC : WD_SHORT_CYC;
  assign wdTimeout = (wdCnt >= wdLimit - 1'b1);
  assign clearAll  = !rstwS || wakeUp || toNormal;
  assign serialErr = (mode == MCSP_NORMAL) && ((frameEnd && !goodFrame)
                     || (goodFrame && rxWd == lastWd) || wdTimeout);

  always_comb begin
    selStatus = statusWord[statusOutSelect];
    if (statusOutSelect >= `MCSP_REG_STAT1
        && statusOutSelect <= `MCSP_REG_STAT7) begin
      selStatus[`MCSP_DSF_BIT] = deviceStatusFlag;
    end
    if (statusOutSelect == `MCSP_REG_STAT1) begin
      selStatus[`MCSP_RCF_BIT] = registerClearedFlag;
    end
  end

  always_comb begin
    next_rxShift     = rxShift;
    next_txShift     = txShift;
    next_bitCnt      = bitCnt;
    next_loadedSel   = loadedSel;
    next_lastWd      = lastWd;
    next_recStage    = recStage;
    next_recoverPend = recoverPend;
    next_wdCnt       = wdTimeout ? wdCnt : wdCnt + 1'b1;
    next_spiFail     = spiFail;
    next_dsf         = deviceStatusFlag;
    next_rcf         = registerClearedFlag;
    next_regFile     = regFile;
    if (csFall) begin
      next_txShift   = {statusOutSelect, 1'b0, selStatus};
      next_bitCnt    = 8'h00;
      next_loadedSel = statusOutSelect;
    end else if (sclkRise) begin
      next_rxShift = {rxShift[14:0], sdiS};
      next_txShift = {txShift[14:0], 1'b0};
      if (bitCnt != 8'hff) next_bitCnt = bitCnt + 1'b1;
    end
    if (goodFrame && loadedSel == `MCSP_REG_STAT1) begin
      next_rcf = 1'b0;
    end
    if (goodFrame && mode == MCSP_NORMAL && rxWd != lastWd) begin
      next_lastWd = rxWd;
      next_wdCnt  = '0;
      if (rxAddr != `MCSP_REG_TEST) begin
        next_regFile[rxAddr] = rxShift[`MCSP_DATA_MSB:0];
      end
    end
    if (mode == MCSP_FAIL) begin
      // Writes only advance the recovery handshake here
      if (goodFrame && !rxWd) begin
        next_recStage = 1'b1;
        next_wdCnt    = '0;
      end else if (goodFrame && rxWd && recStage && !wdTimeout) begin
        next_recoverPend = 1'b1;
      end else if (wdTimeout) begin
        next_recStage = 1'b0;
      end
    end else begin
      next_recStage    = 1'b0;
      next_recoverPend = 1'b0;
    end
    if (toFail) begin
      for (int i = 0; i < 16; i++) begin
        next_regFile[i] = `MCSP_REG_RESET;
      end
    end
    if (clearAll) begin
      for (int i = 0; i < 16; i++) begin
        next_regFile[i] = `MCSP_REG_RESET;
      end
      next_lastWd   = 1'b1;
      next_wdCnt    = '0;
      next_spiFail  = 1'b0;
      next_dsf      = 1'b0;
      next_rcf      = 1'b0;
      next_recStage = 1'b0;
    end
    if (toNormal) begin
      next_dsf = 1'b1;
      next_rcf = 1'b1;
    end
    if (serialErr) begin
      next_spiFail = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rxShift             <= '0;
      txShift             <= '0;
      bitCnt              <= '0;
      sclkPrev            <= 1'b0;
      csPrev              <= 1'b1;
      loadedSel           <= '0;
      lastWd              <= 1'b1;
      recStage            <= 1'b0;
      recoverPend         <= 1'b0;
      wdCnt               <= '0;
      spiFail             <= 1'b0;
      deviceStatusFlag    <= 1'b0;
      registerClearedFlag <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        regFile[i] <= `MCSP_REG_RESET;
      end
    end else begin
      rxShift             <= next_rxShift;
      txShift             <= next_txShift;
      bitCnt              <= next_bitCnt;
      sclkPrev            <= sclkS;
      csPrev              <= csS;
      loadedSel           <= next_loadedSel;
      lastWd              <= next_lastWd;
      recStage            <= next_recStage;
      recoverPend         <= next_recoverPend;
      wdCnt               <= next_wdCnt;
      spiFail             <= next_spiFail;
      deviceStatusFlag    <= next_dsf;
      registerClearedFlag <= next_rcf;
      regFile             <= next_regFile;
    end
  end

  assign channelOnBit    = regFile[`MCSP_REG_OUTCTL][5:0];
  assign statusOutSelect = regFile[`MCSP_REG_INIT][`MCSP_SOA_MSB:0];
  for (genvar g = 0; g < 4; g++) begin : gSel
    assign directSel[g] = regFile[`MCSP_REG_INEN][2*g];
  end
  assign sdo   = txShift[15];
  // No stuck-line detector, so diagnosis stays up in Fail
  assign sdoOe = !csS && rstwS && diagAvail && (mode != MCSP_SLEEP);

  // Registered power-side outputs
  logic [5:0] next_ch;
  logic [4:0] next_ocStart;

  always_comb begin
    next_ch      = '0;
    next_ocStart = '0;
    case (mode)
      MCSP_NORMAL: begin
        for (int i = 0; i < 4; i++) begin
          next_ch[i] = directSel[i] ? directS[i] : channelOnBit[i];
        end
        next_ch[5:4] = channelOnBit[5:4];
        next_ocStart = next_ch[4:0] & ~channelControl[4:0];
      end
      MCSP_FAIL: begin
        next_ch[3:0] = directS & ~latchedOff;
        next_ocStart = {1'b0, wakeS & ~wakePrev};
      end
      default: next_ch = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      channelControl <= '0;
      ocWindowStart  <= '0;
      lowOcProfile   <= 1'b0;
      autoRestart    <= '0;
      faultReportEn  <= 1'b0;
      pwmEnable      <= 1'b0;
      analogFbEnable <= 1'b0;
      initDone       <= 1'b0;
      diagAvail      <= 1'b0;
    end else begin
      channelControl <= next_ch;
      ocWindowStart  <= next_ocStart;
      lowOcProfile   <= (mode == MCSP_FAIL);
      autoRestart    <= (mode == MCSP_FAIL) ?
                        (overloadIn | {4{underVoltIn}}) & ~latchedOff
                        : 4'h0;
      faultReportEn  <= (mode != MCSP_SLEEP) && (blankCnt == '0);
      pwmEnable      <= (mode == MCSP_NORMAL);
      analogFbEnable <= (mode == MCSP_NORMAL);
      initDone       <= (mode != MCSP_SLEEP) && (initCnt == '0);
      diagAvail      <= (mode != MCSP_SLEEP);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence seqFailExit;
    (mode == MCSP_FAIL) ##1 (mode == MCSP_NORMAL);
  endsequence

  AST_SLEEP_OFF: assert property (
    (mode == MCSP_SLEEP) ##1 (mode == MCSP_SLEEP) |-> channelControl == '0)
    else $error("Output on in sleep");
  AST_NORMAL_ENTRY: assert property (
    (mode == MCSP_SLEEP && wakeCond && !limpS) |=> mode == MCSP_NORMAL)
    else $error("Wake did not reach normal");
  AST_FAIL_ENTRY: assert property (
    (mode == MCSP_NORMAL && wakeCond && failCond) |=> mode == MCSP_FAIL)
    else $error("Fail not entered");
  AST_FAIL_OUT56: assert property (
    (mode == MCSP_FAIL) |=> channelControl[5:4] == 2'b00)
    else $error("Outputs 5-6 on in fail");
  AST_FAIL_NOWRITE: assert property (
    (mode == MCSP_FAIL && !toNormal && wakeCond && rstwS)
    |=> $stable(channelOnBit))
    else $error("Write took effect in fail");
  AST_SO_HIZ: assert property (
    csS |-> !sdoOe)
    else $error("Output driven while deselected");
  AST_MOD16: assert property (
    (mode == MCSP_NORMAL && frameEnd && !goodFrame) |=> spiFail)
    else $error("Bad bit count not flagged");
  AST_RECOVER_FLAGS: assert property (
    seqFailExit |-> deviceStatusFlag && registerClearedFlag)
    else $error("Status flags not set on recovery");
  AST_LATCH: assert property (
    (mode == MCSP_FAIL && wakeCond && rstwS && !toNormal && overTempIn[0])
    |=> latchedOff[0] ##1 !channelControl[0])
    else $error("Overtemperature did not latch off");
  AST_OC_START: assert property (
    ($rose(channelControl[0]) && $past(mode) == MCSP_NORMAL)
    |-> ocWindowStart[0])
    else $error("No overcurrent window on channel rise");
  AST_SLEEP_RETURN: assert property (
    !wakeCond |=> mode == MCSP_SLEEP)
    else $error("No return to sleep");
endmodule // mcsp_mode_ctrl

//--- mcsp_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
module mcsp_mode_ctrl_tb_top
  import mcsp_pkg::*;
;
  logic              clk_sys, nrst, resetWakeIn, limpHomeIn;
  logic              sclkIn, chipSelectN, sdi, underVoltIn, ochiCh1In;
  logic              sdo, sdoOe, lowOcProfile, faultReportEn, pwmEnable;
  logic              analogFbEnable, initDone, diagAvail;
  logic              deviceStatusFlag, registerClearedFlag, wd;
  logic [3:0]        wakeIn, directIn, overloadIn, overTempIn;
  logic [3:0]        severeShortIn, autoRestart, latchedOff;
  logic [3:0]        directSel, statusOutSelect;
  logic [15:0][10:0] statusWord;
  logic [5:0]        channelControl, channelOnBit;
  logic [4:0]        ocWindowStart;
  logic [15:0]       rx;
  mcsp_mode_t        mode;
  int                errCount, checkCount, cyc;

  // Watchdog shortened so a timeout fits the run
  mcsp_mode_ctrl #(.WD_SHORT_US(200), .WD_LONG_US(400), .BLANK_US(2)) dut (
    .clk_sys, .nrst, .resetWakeIn, .wakeIn, .limpHomeIn, .directIn,
    .sclkIn, .chipSelectN, .sdi, .overloadIn, .underVoltIn, .overTempIn,
    .ochiCh1In, .severeShortIn, .statusWord, .sdo, .sdoOe,
    .channelControl, .ocWindowStart, .lowOcProfile, .autoRestart,
    .latchedOff, .faultReportEn, .pwmEnable, .analogFbEnable, .initDone,
    .diagAvail, .mode, .channelOnBit, .directSel, .statusOutSelect,
    .deviceStatusFlag, .registerClearedFlag);

  mcsp_host_model host (.clk_sys, .sdo, .sdoOe, .sclkIn, .chipSelectN,
    .sdi);

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t ns: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkMode(input mcsp_mode_t m);
    check(16'(mode), 16'(m));
  endtask

  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    host.xfer({a, wd, d}, 16, rx);
    wd = ~wd;
  endtask

  // Sample on the falling edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic endTest(input string s);
    $display("Test %s done", s);
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errCount++;
      finish_test();
    end
  end

  initial begin
    nrst = 1'b0;
    resetWakeIn = 1'b0;
    wakeIn = 4'h0;
    limpHomeIn = 1'b0;
    directIn = 4'h0;
    underVoltIn = 1'b0;
    ochiCh1In = 1'b0;
    overloadIn = 4'h0;
    overTempIn = 4'h0;
    severeShortIn = 4'h0;
    wd = 1'b0;
    errCount = 0;
    checkCount = 0;
    cyc = 0;
    for (int i = 0; i < 16; i++) statusWord[i] = {1'b0, 6'h15, 4'(i)};
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(4);
    chkMode(MCSP_SLEEP);
    check(16'(channelControl), 16'h0000);
    check(16'(sdoOe), 16'h0000);
    endTest("reset");
    @(posedge clk_sys);
    wakeIn <= 4'h4;
    tick(10);
    chkMode(MCSP_NORMAL);
    @(posedge clk_sys);
    wakeIn <= 4'h0;
    tick(10);
    chkMode(MCSP_SLEEP);
    endTest("wake");
    @(posedge clk_sys);
    resetWakeIn <= 1'b1;
    directIn <= 4'h5;
    tick(300);
    chkMode(MCSP_NORMAL);
    check(16'(initDone), 16'h0000);
    tick(230);
    check(16'(initDone), 16'h0001);
    check(16'(faultReportEn), 16'h0001);
    check(16'(channelOnBit), 16'h0000);
    endTest("startup");
    wr(4'h8, 11'h03f);
    tick(0);
    check(16'(channelOnBit), 16'h003f);
    check(16'(channelControl), 16'h003f);
    check(16'(pwmEnable), 16'h0001);
    wr(4'hb, 11'h055);
    tick(0);
    check(16'(directSel), 16'h000f);
    check(16'(channelControl), 16'h0035);
    wr(4'h0, 11'h005);
    wr(4'h0, 11'h005);
    tick(0);
    check(16'(statusOutSelect), 16'h0005);
    check(rx, {4'h5, 1'b0, statusWord[5]});
    check(16'(sdoOe), 16'h0000);
    endTest("normal");
    @(posedge clk_sys);
    limpHomeIn <= 1'b1;
    directIn <= 4'ha;
    tick(10);
    chkMode(MCSP_FAIL);
    check(16'(channelControl), 16'h000a);
    check(16'(pwmEnable), 16'h0000);
    check(16'(analogFbEnable), 16'h0000);
    check(16'(lowOcProfile), 16'h0001);
    check(16'(channelOnBit), 16'h0000);
    check(16'(diagAvail), 16'h0001);
    wd = 1'b1;
    wr(4'h8, 11'h03f);
    tick(0);
    check(16'(channelOnBit), 16'h0000);
    endTest("fail");
    @(posedge clk_sys);
    limpHomeIn <= 1'b0;
    tick(8);
    wd = 1'b0;
    wr(4'h0, 11'h000);
    wr(4'h0, 11'h000);
    tick(0);
    chkMode(MCSP_NORMAL);
    check(16'(deviceStatusFlag), 16'h0001);
    check(16'(registerClearedFlag), 16'h0001);
    wr(4'h0, 11'h001);
    wr(4'h0, 11'h001);
    tick(0);
    check(16'(rx[15:10]), 16'h0005);
    check(16'(registerClearedFlag), 16'h0000);
    endTest("recovery");
    // No toggle for longer than the shortened timeout
    tick(2100);
    chkMode(MCSP_FAIL);
    @(posedge clk_sys);
    overTempIn <= 4'h2;
    overloadIn <= 4'h1;
    tick(6);
    check(16'(latchedOff), 16'h0002);
    check(16'(autoRestart[0]), 16'h0001);
    @(posedge clk_sys);
    overTempIn <= 4'h0;
    overloadIn <= 4'h0;
    tick(6);
    check(16'(latchedOff), 16'h0002);
    @(posedge clk_sys);
    resetWakeIn <= 1'b0;
    tick(10);
    chkMode(MCSP_SLEEP);
    check(16'(channelControl), 16'h0000);
    check(16'(latchedOff), 16'h0000);
    endTest("watchdog");
    finish_test();
  end
endmodule // mcsp_mode_ctrl_tb_top

//--- mcsp_pkg.sv
package mcsp_pkg;
  typedef enum logic [1:0] {
    MCSP_SLEEP  = 2'b00,
    MCSP_NORMAL = 2'b01,
    MCSP_FAIL   = 2'b11
  } mcsp_mode_t;
endpackage

//--- mcsp_sync3.sv
`timescale 1ns/1ps
module mcsp_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // Accept a change only when the two later stages agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end
endmodule // mcsp_sync3
